// >>> hdl/aswp_pkg.sv
// Shared constants, encodings and state types of the AXI4 write path
package aswp_pkg;
	localparam int          ADDR_W      = 32;
	localparam int          LEN_W       = 8;
	localparam int          SIZE_W      = 3;
	localparam int          BURST_W     = 2;
	localparam int          RESP_W      = 2;
	localparam int          ID_W_MAX    = 16;
	localparam int          LANE_W      = 8;
	localparam logic [1:0]  BURST_FIXED = 2'h0;
	localparam logic [1:0]  BURST_INCR  = 2'h1;
	localparam logic [1:0]  BURST_WRAP  = 2'h2;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;

	typedef enum {SLV_IDLE, SLV_DATA, SLV_RESP} aswp_slv_state_e;
	typedef enum {MST_IDLE, MST_ADDR, MST_LOAD, MST_SEND, MST_RESP} aswp_mst_state_e;

	// Size code that spans the whole data bus
	function automatic logic [SIZE_W-1:0] aswp_full_size(input int data_w);
		int bytes_log;
		bytes_log = $clog2(data_w / LANE_W);
		return bytes_log[SIZE_W-1:0];
	endfunction
endpackage

// >>> hdl/aswp_if.sv
// Write address, write data and write response channels between master and slave
interface aswp_if #(
	parameter int DATA_W = 32,
	parameter int ID_W   = 4
) (
	input logic core_clk,
	input logic rst_n
);
	logic [ID_W-1:0]                  awid;
	logic [aswp_pkg::ADDR_W-1:0]      awaddr;
	logic [aswp_pkg::LEN_W-1:0]       awlen;
	logic [aswp_pkg::SIZE_W-1:0]      awsize;
	logic [aswp_pkg::BURST_W-1:0]     awburst;
	logic                             awvalid;
	logic                             awready;
	logic [DATA_W-1:0]                wdata;
	logic [DATA_W/8-1:0]              wstrb;
	logic                             wlast;
	logic                             wvalid;
	logic                             wready;
	logic [ID_W-1:0]                  bid;
	logic [aswp_pkg::RESP_W-1:0]      bresp;
	logic                             bvalid;
	logic                             bready;

	modport slave (
		input  core_clk, rst_n, awid, awaddr, awlen, awsize, awburst, awvalid,
		input  wdata, wstrb, wlast, wvalid, bready,
		output awready, wready, bid, bresp, bvalid
	);
	modport master (
		input  core_clk, rst_n, awready, wready, bid, bresp, bvalid,
		output awid, awaddr, awlen, awsize, awburst, awvalid,
		output wdata, wstrb, wlast, wvalid, bready
	);
endinterface

// >>> hdl/aswp_addr_step.sv
// Next beat address of a burst from the current address and burst controls
module aswp_addr_step (
	input  wire logic [aswp_pkg::ADDR_W-1:0]  addr,
	input  wire logic [aswp_pkg::SIZE_W-1:0]  size,
	input  wire logic [aswp_pkg::LEN_W-1:0]   len,
	input  wire logic [aswp_pkg::BURST_W-1:0] burst,
	output logic      [aswp_pkg::ADDR_W-1:0]  next_addr
);
	logic [aswp_pkg::ADDR_W-1:0] step;
	logic [aswp_pkg::ADDR_W-1:0] incr;
	logic [aswp_pkg::ADDR_W-1:0] wrap_mask;

	always_comb begin
		step      = 32'h1 << size;
		// Unaligned starts snap to the size boundary after the first beat
		incr      = (addr & ~(step - 32'h1)) + step;
		wrap_mask = (({24'h0, len} + 32'h1) << size) - 32'h1;
		unique case (burst)
			aswp_pkg::BURST_INCR: next_addr = incr;
			aswp_pkg::BURST_WRAP: next_addr = (addr & ~wrap_mask) | (incr & wrap_mask);
			// Fixed and reserved codes keep the address
			default:              next_addr = addr;
		endcase
	end
endmodule

// >>> hdl/aswp_slave.sv
// Memory-side end: AXI4 write slave driving a byte-enabled memory write port
module aswp_slave #(
	parameter int DATA_W  = 32,
	parameter int ID_W    = 4,
	parameter bit MEM_CFG = 1'b1,
	parameter bit ID_EN   = 1'b1
) (
	aswp_if.slave                            bus,
	output logic                             mem_wr_en,
	output logic [DATA_W/8-1:0]              mem_wr_be,
	output logic [aswp_pkg::ADDR_W-1:0]      mem_wr_addr,
	output logic [DATA_W-1:0]                mem_wr_data,
	output logic                             busy
);
	localparam int STRB_W = DATA_W / 8;
	// Widths outside 32..256 (memory) or 8..256 (peripheral) are not supported
	localparam logic [aswp_pkg::SIZE_W-1:0] FULL_SIZE = aswp_pkg::aswp_full_size(DATA_W);
	localparam bit TAGGED = MEM_CFG && ID_EN;

	aswp_pkg::aswp_slv_state_e         state_reg, state_next;
	logic                              awready_reg, awready_next;
	logic                              wready_reg, wready_next;
	logic                              bvalid_reg, bvalid_next;
	logic [ID_W-1:0]                   bid_reg, bid_next;
	logic [aswp_pkg::ADDR_W-1:0]       addr_reg, addr_next;
	logic [aswp_pkg::SIZE_W-1:0]       size_reg, size_next;
	logic [aswp_pkg::LEN_W-1:0]        len_reg, len_next;
	logic [aswp_pkg::BURST_W-1:0]      burst_reg, burst_next;
	logic [aswp_pkg::LEN_W-1:0]        beats_reg, beats_next;
	logic                              mem_wr_en_reg, mem_wr_en_next;
	logic [STRB_W-1:0]                 mem_wr_be_reg, mem_wr_be_next;
	logic [aswp_pkg::ADDR_W-1:0]       mem_wr_addr_reg, mem_wr_addr_next;
	logic [DATA_W-1:0]                 mem_wr_data_reg, mem_wr_data_next;
	logic                              busy_reg, busy_next;
	logic [aswp_pkg::ADDR_W-1:0]       step_addr;
	logic [DATA_W-1:0]                 lane_data;
	logic [ID_W-1:0]                   id_in;
	logic [aswp_pkg::SIZE_W-1:0]       size_in;
	logic [aswp_pkg::BURST_W-1:0]      burst_in;

	// Peripheral build ignores tag, size and burst type wires entirely
	assign id_in    = TAGGED ? bus.awid : '0;
	assign size_in  = MEM_CFG ? bus.awsize : FULL_SIZE;
	assign burst_in = MEM_CFG ? bus.awburst : aswp_pkg::BURST_INCR;

	aswp_addr_step aswp_addr_step_inst (
		.addr      (addr_reg),
		.size      (size_reg),
		.len       (len_reg),
		.burst     (burst_reg),
		.next_addr (step_addr)
	);

	// Unstrobed lanes carry zero so a careless memory cannot pick up stale bytes
	for (genvar n = 0; n < STRB_W; n++) begin : g_lane
		assign lane_data[n*aswp_pkg::LANE_W +: aswp_pkg::LANE_W] =
			bus.wstrb[n] ? bus.wdata[n*aswp_pkg::LANE_W +: aswp_pkg::LANE_W] : 8'h00;
	end

	always_comb begin
		state_next       = state_reg;
		awready_next     = awready_reg;
		wready_next      = wready_reg;
		bvalid_next      = bvalid_reg;
		bid_next         = bid_reg;
		addr_next        = addr_reg;
		size_next        = size_reg;
		len_next         = len_reg;
		burst_next       = burst_reg;
		beats_next       = beats_reg;
		mem_wr_en_next   = 1'b0;
		mem_wr_be_next   = mem_wr_be_reg;
		mem_wr_addr_next = mem_wr_addr_reg;
		mem_wr_data_next = mem_wr_data_reg;
		busy_next        = busy_reg;
		unique case (state_reg)
			aswp_pkg::SLV_IDLE: begin
				if (bus.awvalid && awready_reg) begin
					addr_next    = bus.awaddr;
					len_next     = bus.awlen;
					beats_next   = bus.awlen;
					size_next    = size_in;
					burst_next   = burst_in;
					bid_next     = id_in;
					awready_next = 1'b0;
					wready_next  = 1'b1;
					busy_next    = 1'b1;
					state_next   = aswp_pkg::SLV_DATA;
				end
			end
			aswp_pkg::SLV_DATA: begin
				if (bus.wvalid && wready_reg) begin
					mem_wr_en_next   = 1'b1;
					mem_wr_be_next   = bus.wstrb;
					mem_wr_addr_next = addr_reg;
					mem_wr_data_next = lane_data;
					addr_next        = step_addr;
					beats_next       = beats_reg - 8'h01;
					// Beat count, not the last marker, closes the burst
					if (beats_reg == 8'h00) begin
						wready_next = 1'b0;
						bvalid_next = 1'b1;
						state_next  = aswp_pkg::SLV_RESP;
					end
				end
			end
			aswp_pkg::SLV_RESP: begin
				if (bus.bready) begin
					bvalid_next  = 1'b0;
					awready_next = 1'b1;
					busy_next    = 1'b0;
					state_next   = aswp_pkg::SLV_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge bus.core_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			state_reg       <= aswp_pkg::SLV_IDLE;
			awready_reg     <= 1'b1;
			wready_reg      <= 1'b0;
			bvalid_reg      <= 1'b0;
			bid_reg         <= '0;
			addr_reg        <= '0;
			size_reg        <= '0;
			len_reg         <= '0;
			burst_reg       <= aswp_pkg::BURST_INCR;
			beats_reg       <= '0;
			mem_wr_en_reg   <= 1'b0;
			mem_wr_be_reg   <= '0;
			mem_wr_addr_reg <= '0;
			mem_wr_data_reg <= '0;
			busy_reg        <= 1'b0;
		end else begin
			state_reg       <= state_next;
			awready_reg     <= awready_next;
			wready_reg      <= wready_next;
			bvalid_reg      <= bvalid_next;
			bid_reg         <= bid_next;
			addr_reg        <= addr_next;
			size_reg        <= size_next;
			len_reg         <= len_next;
			burst_reg       <= burst_next;
			beats_reg       <= beats_next;
			mem_wr_en_reg   <= mem_wr_en_next;
			mem_wr_be_reg   <= mem_wr_be_next;
			mem_wr_addr_reg <= mem_wr_addr_next;
			mem_wr_data_reg <= mem_wr_data_next;
			busy_reg        <= busy_next;
		end
	end

	assign bus.awready  = awready_reg;
	assign bus.wready   = wready_reg;
	assign bus.bvalid   = bvalid_reg;
	assign bus.bid      = bid_reg;
	// Never an error status; untagged builds return a zero tag on bid
	assign bus.bresp    = aswp_pkg::RESP_OKAY;
	assign mem_wr_en    = mem_wr_en_reg;
	assign mem_wr_be    = mem_wr_be_reg;
	assign mem_wr_addr  = mem_wr_addr_reg;
	assign mem_wr_data  = mem_wr_data_reg;
	assign busy         = busy_reg;
endmodule

// >>> hdl/aswp_master.sv
// Bus-master end: turns user burst commands and data beats into AXI4 writes
module aswp_master #(
	parameter int DATA_W = 32,
	parameter int ID_W   = 4
) (
	aswp_if.master                           bus,
	input  wire logic                        cmd_valid,
	input  wire logic [aswp_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic [aswp_pkg::LEN_W-1:0]  cmd_len,
	input  wire logic [aswp_pkg::SIZE_W-1:0] cmd_size,
	input  wire logic [aswp_pkg::BURST_W-1:0] cmd_burst,
	input  wire logic [ID_W-1:0]             cmd_id,
	output logic                             cmd_ready,
	input  wire logic                        dat_valid,
	input  wire logic [DATA_W-1:0]           dat_data,
	input  wire logic [DATA_W/8-1:0]         dat_strb,
	output logic                             dat_ready,
	output logic                             done,
	output logic [ID_W-1:0]                  done_id,
	output logic [aswp_pkg::RESP_W-1:0]      done_resp
);
	aswp_pkg::aswp_mst_state_e     state_reg, state_next;
	logic                          cmd_ready_reg, cmd_ready_next;
	logic                          dat_ready_reg, dat_ready_next;
	logic                          awvalid_reg, awvalid_next;
	logic [aswp_pkg::ADDR_W-1:0]   awaddr_reg, awaddr_next;
	logic [aswp_pkg::LEN_W-1:0]    awlen_reg, awlen_next;
	logic [aswp_pkg::SIZE_W-1:0]   awsize_reg, awsize_next;
	logic [aswp_pkg::BURST_W-1:0]  awburst_reg, awburst_next;
	logic [ID_W-1:0]               awid_reg, awid_next;
	logic                          wvalid_reg, wvalid_next;
	logic [DATA_W-1:0]             wdata_reg, wdata_next;
	logic [DATA_W/8-1:0]           wstrb_reg, wstrb_next;
	logic                          wlast_reg, wlast_next;
	logic [aswp_pkg::LEN_W-1:0]    beats_reg, beats_next;
	logic                          bready_reg, bready_next;
	logic                          done_reg, done_next;
	logic [ID_W-1:0]               done_id_reg, done_id_next;
	logic [aswp_pkg::RESP_W-1:0]   done_resp_reg, done_resp_next;

	always_comb begin
		state_next     = state_reg;
		cmd_ready_next = cmd_ready_reg;
		dat_ready_next = dat_ready_reg;
		awvalid_next   = awvalid_reg;
		awaddr_next    = awaddr_reg;
		awlen_next     = awlen_reg;
		awsize_next    = awsize_reg;
		awburst_next   = awburst_reg;
		awid_next      = awid_reg;
		wvalid_next    = wvalid_reg;
		wdata_next     = wdata_reg;
		wstrb_next     = wstrb_reg;
		wlast_next     = wlast_reg;
		beats_next     = beats_reg;
		bready_next    = bready_reg;
		done_next      = 1'b0;
		done_id_next   = done_id_reg;
		done_resp_next = done_resp_reg;
		unique case (state_reg)
			aswp_pkg::MST_IDLE: begin
				if (cmd_valid) begin
					// Fields sit in registers, so they cannot move before acceptance
					awaddr_next    = cmd_addr;
					awlen_next     = cmd_len;
					awsize_next    = cmd_size;
					awburst_next   = cmd_burst;
					awid_next      = cmd_id;
					beats_next     = cmd_len;
					awvalid_next   = 1'b1;
					cmd_ready_next = 1'b0;
					state_next     = aswp_pkg::MST_ADDR;
				end
			end
			aswp_pkg::MST_ADDR: begin
				if (bus.awready) begin
					awvalid_next   = 1'b0;
					dat_ready_next = 1'b1;
					state_next     = aswp_pkg::MST_LOAD;
				end
			end
			aswp_pkg::MST_LOAD: begin
				if (dat_valid) begin
					wdata_next     = dat_data;
					wstrb_next     = dat_strb;
					wvalid_next    = 1'b1;
					wlast_next     = (beats_reg == 8'h00);
					dat_ready_next = 1'b0;
					state_next     = aswp_pkg::MST_SEND;
				end
			end
			aswp_pkg::MST_SEND: begin
				if (bus.wready) begin
					wvalid_next = 1'b0;
					wlast_next  = 1'b0;
					if (wlast_reg) begin
						bready_next = 1'b1;
						state_next  = aswp_pkg::MST_RESP;
					end else begin
						beats_next     = beats_reg - 8'h01;
						dat_ready_next = 1'b1;
						state_next     = aswp_pkg::MST_LOAD;
					end
				end
			end
			aswp_pkg::MST_RESP: begin
				if (bus.bvalid) begin
					bready_next    = 1'b0;
					done_next      = 1'b1;
					done_id_next   = bus.bid;
					done_resp_next = bus.bresp;
					cmd_ready_next = 1'b1;
					state_next     = aswp_pkg::MST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge bus.core_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			state_reg     <= aswp_pkg::MST_IDLE;
			cmd_ready_reg <= 1'b1;
			dat_ready_reg <= 1'b0;
			awvalid_reg   <= 1'b0;
			awaddr_reg    <= '0;
			awlen_reg     <= '0;
			awsize_reg    <= '0;
			awburst_reg   <= aswp_pkg::BURST_INCR;
			awid_reg      <= '0;
			wvalid_reg    <= 1'b0;
			wdata_reg     <= '0;
			wstrb_reg     <= '0;
			wlast_reg     <= 1'b0;
			beats_reg     <= '0;
			bready_reg    <= 1'b0;
			done_reg      <= 1'b0;
			done_id_reg   <= '0;
			done_resp_reg <= '0;
		end else begin
			state_reg     <= state_next;
			cmd_ready_reg <= cmd_ready_next;
			dat_ready_reg <= dat_ready_next;
			awvalid_reg   <= awvalid_next;
			awaddr_reg    <= awaddr_next;
			awlen_reg     <= awlen_next;
			awsize_reg    <= awsize_next;
			awburst_reg   <= awburst_next;
			awid_reg      <= awid_next;
			wvalid_reg    <= wvalid_next;
			wdata_reg     <= wdata_next;
			wstrb_reg     <= wstrb_next;
			wlast_reg     <= wlast_next;
			beats_reg     <= beats_next;
			bready_reg    <= bready_next;
			done_reg      <= done_next;
			done_id_reg   <= done_id_next;
			done_resp_reg <= done_resp_next;
		end
	end

	assign bus.awvalid = awvalid_reg;
	assign bus.awaddr  = awaddr_reg;
	assign bus.awlen   = awlen_reg;
	assign bus.awsize  = awsize_reg;
	assign bus.awburst = awburst_reg;
	assign bus.awid    = awid_reg;
	assign bus.wvalid  = wvalid_reg;
	assign bus.wdata   = wdata_reg;
	assign bus.wstrb   = wstrb_reg;
	assign bus.wlast   = wlast_reg;
	assign bus.bready  = bready_reg;
	assign cmd_ready   = cmd_ready_reg;
	assign dat_ready   = dat_ready_reg;
	assign done        = done_reg;
	assign done_id     = done_id_reg;
	assign done_resp   = done_resp_reg;
endmodule

// >>> sim/aswp_assertions.sv
// Concurrent checks on the write channels between master and memory slave
module aswp_assertions #(
	parameter int DATA_W = 32,
	parameter int ID_W   = 4
) (
	input wire logic                core_clk,
	input wire logic                rst_n,
	input wire logic [ID_W-1:0]     awid,
	input wire logic [31:0]         awaddr,
	input wire logic [7:0]          awlen,
	input wire logic [2:0]          awsize,
	input wire logic [1:0]          awburst,
	input wire logic                awvalid,
	input wire logic                awready,
	input wire logic [DATA_W-1:0]   wdata,
	input wire logic [DATA_W/8-1:0] wstrb,
	input wire logic                wlast,
	input wire logic                wvalid,
	input wire logic                wready,
	input wire logic [ID_W-1:0]     bid,
	input wire logic [1:0]          bresp,
	input wire logic                bvalid,
	input wire logic                bready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0]      cnt_reg;
	logic [8:0]      cnt_next;
	logic [7:0]      len_reg;
	logic [7:0]      len_next;
	logic [ID_W-1:0] id_reg;
	logic [ID_W-1:0] id_next;
	logic            last_beat;

	// Beats are counted from the address accept so the burst end is judged by length, not by wlast
	always_comb begin
		cnt_next = cnt_reg;
		len_next = len_reg;
		id_next = id_reg;
		if (awvalid && awready) begin
			cnt_next = 9'h0;
			len_next = awlen;
			id_next = awid;
		end else if (wvalid && wready) begin
			cnt_next = cnt_reg + 9'h1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 9'h0;
			len_reg <= 8'h0;
			id_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
			len_reg <= len_next;
			id_reg <= id_next;
		end
	end
	assign last_beat = (cnt_reg == {1'b0, len_reg});

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_aw_opens_data: assert property (awvalid && awready |=> !awready && wready)
		else $error("address accept did not open data phase");
	a_aw_shut_busy: assert property (wready || bvalid |-> !awready)
		else $error("address ready during burst");
	a_last_closes: assert property (wvalid && wready && last_beat |=> !wready && bvalid)
		else $error("last beat did not close data phase");
	a_beat_total: assert property ($rose(bvalid) |-> cnt_reg == {1'b0, len_reg} + 9'h1)
		else $error("beat count differs from length");
	a_wlast_final: assert property (wvalid && wready |-> wlast == last_beat)
		else $error("wlast not on final beat only");
	a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bid))
		else $error("response dropped before ready");
	a_resp_release: assert property (bvalid && bready |=> !bvalid ##0 awready)
		else $error("response not released after handshake");
	a_resp_okay: assert property (bvalid |-> bresp == aswp_pkg::RESP_OKAY)
		else $error("response status not normal");
	a_tag_match: assert property (bvalid |-> bid == id_reg)
		else $error("response tag differs from address tag");
	a_aw_drop: assert property (awvalid && awready |=> !awvalid)
		else $error("address valid kept after accept");
	a_w_drop: assert property (wvalid && wready |=> !wvalid)
		else $error("data valid kept without new beat");

	c_wrap_accept: cover property (awvalid && awready && awburst == aswp_pkg::BURST_WRAP);
	c_long_accept: cover property (awvalid && awready && awlen == 8'hff);
	c_resp_done: cover property (bvalid && bready);
endmodule

// >>> sim/axi4_slave_write_path_bench.sv
// Bench: master joined to memory slave, and a peripheral slave driven by hand
module axi4_slave_write_path_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, rst_n, cmd_valid, cmd_ready, dat_valid, dat_ready, done;
	logic        mem_wr_en, busy, p_en, p_busy;
	logic [31:0] cmd_addr, dat_data, mem_wr_addr, mem_wr_data, p_addr, p_data;
	logic [7:0]  cmd_len;
	logic [2:0]  cmd_size;
	logic [1:0]  cmd_burst, done_resp;
	logic [3:0]  cmd_id, dat_strb, done_id, mem_wr_be, p_be;
	logic [67:0] got[$];
	logic [67:0] pgot[$];
	int          n_mismatch = 0;
	int          check_count = 0;

	// Default widths (32-bit data, 4-bit tag) match the bench's own signal widths
	aswp_if bus_if (.core_clk(core_clk), .rst_n(rst_n));
	aswp_if per_if (.core_clk(core_clk), .rst_n(rst_n));
	aswp_master aswp_master_inst (.bus(bus_if.master), .cmd_valid(cmd_valid),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_size(cmd_size), .cmd_burst(cmd_burst), .cmd_id(cmd_id),
		.cmd_ready(cmd_ready), .dat_valid(dat_valid), .dat_data(dat_data), .dat_strb(dat_strb),
		.dat_ready(dat_ready), .done(done), .done_id(done_id), .done_resp(done_resp));
	aswp_slave aswp_slave_inst (.bus(bus_if.slave),
		.mem_wr_en(mem_wr_en), .mem_wr_be(mem_wr_be), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.busy(busy));
	// Peripheral build faces the bench so faults of the master side can be made on purpose
	aswp_slave #(.MEM_CFG(1'b0), .ID_EN(1'b0)) aswp_slave_per_inst (.bus(per_if.slave),
		.mem_wr_en(p_en), .mem_wr_be(p_be), .mem_wr_addr(p_addr), .mem_wr_data(p_data), .busy(p_busy));
	aswp_assertions aswp_assertions_inst (.core_clk(core_clk), .rst_n(rst_n),
		.awid(bus_if.awid), .awaddr(bus_if.awaddr), .awlen(bus_if.awlen), .awsize(bus_if.awsize),
		.awburst(bus_if.awburst), .awvalid(bus_if.awvalid), .awready(bus_if.awready), .wdata(bus_if.wdata),
		.wstrb(bus_if.wstrb), .wlast(bus_if.wlast), .wvalid(bus_if.wvalid), .wready(bus_if.wready),
		.bid(bus_if.bid), .bresp(bus_if.bresp), .bvalid(bus_if.bvalid), .bready(bus_if.bready));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (mem_wr_en === 1'b1) got.push_back({mem_wr_addr, mem_wr_be, mem_wr_data});
		if (p_en === 1'b1) pgot.push_back({p_addr, p_be, p_data});
	end

	task automatic chk_val(input string what, input logic [67:0] exp, input logic [67:0] seen);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chk_flag(input string what, input logic exp, input logic seen);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] bdat(input int k, input logic [3:0] id);
		return {8'hc3, 8'(k), 8'(~k), 4'h0, id};
	endfunction
	function automatic logic [3:0] bstrb(input int k);
		return 4'(k) ^ 4'ha;
	endfunction
	// Unstrobed lanes read back as zero on the memory port
	function automatic logic [67:0] bexp(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		for (int i = 0; i < 4; i++) m[8*i +: 8] = s[i] ? 8'hff : 8'h00;
		return {a, s, d & m};
	endfunction

	task automatic run_burst(input logic [31:0] a, input logic [7:0] len, input logic [2:0] sz,
		input logic [1:0] bt, input logic [3:0] id);
		logic [31:0] ea;
		logic [31:0] nb;
		logic [31:0] wsz;
		got.delete();
		cmd_valid <= 1'b1;
		cmd_addr <= a;
		cmd_len <= len;
		cmd_size <= sz;
		cmd_burst <= bt;
		cmd_id <= id;
		@(posedge core_clk iff cmd_ready === 1'b1);
		cmd_valid <= 1'b0;
		for (int k = 0; k <= int'(len); k++) begin
			dat_valid <= 1'b1;
			dat_data <= bdat(k, id);
			dat_strb <= bstrb(k);
			@(posedge core_clk iff dat_ready === 1'b1);
			if (k == 0) chk_flag("busy", 1'b1, busy);
		end
		dat_valid <= 1'b0;
		@(posedge core_clk iff done === 1'b1);
		chk_val("done_id", 68'(id), 68'(done_id));
		chk_val("done_resp", 68'(aswp_pkg::RESP_OKAY), 68'(done_resp));
		chk_val("beats", 68'(len) + 68'h1, 68'(got.size()));
		nb = 32'h1 << sz;
		wsz = nb * (32'(len) + 32'h1);
		ea = a;
		for (int k = 0; k < got.size(); k++) begin
			chk_val("beat", bexp(ea, bdat(k, id), bstrb(k)), got[k]);
			if (bt == aswp_pkg::BURST_INCR) ea = (ea & ~(nb - 32'h1)) + nb;
			else if (bt == aswp_pkg::BURST_WRAP) ea = (ea & ~(wsz - 32'h1)) | ((ea + nb) & (wsz - 32'h1));
		end
	endtask

	task automatic t_bursts();
		run_burst(32'h1000, 8'h03, 3'h2, aswp_pkg::BURST_INCR, 4'h5);
		run_burst(32'h0018, 8'h03, 3'h2, aswp_pkg::BURST_WRAP, 4'ha);
		run_burst(32'h0101, 8'h02, 3'h1, aswp_pkg::BURST_INCR, 4'h3);
		run_burst(32'h0040, 8'h02, 3'h2, aswp_pkg::BURST_FIXED, 4'h0);
		$display("burst kinds done");
	endtask
	task automatic t_lengths();
		run_burst(32'h2000, 8'hff, 3'h2, aswp_pkg::BURST_INCR, 4'hf);
		run_burst(32'h3000, 8'h00, 3'h2, aswp_pkg::BURST_INCR, 4'h1);
		$display("length extremes done");
	endtask
	task automatic t_reset();
		cmd_valid <= 1'b1;
		cmd_len <= 8'h07;
		@(posedge core_clk iff cmd_ready === 1'b1);
		cmd_valid <= 1'b0;
		dat_valid <= 1'b1;
		@(posedge core_clk iff dat_ready === 1'b1);
		dat_valid <= 1'b0;
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk_flag("awready", 1'b1, bus_if.awready);
		chk_flag("wready", 1'b0, bus_if.wready);
		chk_flag("bvalid", 1'b0, bus_if.bvalid);
		chk_flag("busy", 1'b0, busy);
		rst_n <= 1'b1;
		@(posedge core_clk);
		run_burst(32'h0500, 8'h01, 3'h2, aswp_pkg::BURST_INCR, 4'h6);
		$display("mid-burst reset done");
	endtask
	task automatic t_periph();
		pgot.delete();
		per_if.awvalid <= 1'b1;
		per_if.awaddr <= 32'h0200;
		per_if.awlen <= 8'h01;
		per_if.awburst <= aswp_pkg::BURST_WRAP;
		per_if.awid <= 4'h9;
		@(posedge core_clk iff per_if.awready === 1'b1);
		per_if.awvalid <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			per_if.wvalid <= 1'b1;
			per_if.wdata <= bdat(k, 4'h9);
			per_if.wstrb <= bstrb(k);
			per_if.wlast <= (k == 0); // Misplaced on purpose
			@(posedge core_clk iff per_if.wready === 1'b1);
		end
		per_if.wvalid <= 1'b0;
		per_if.wdata <= ~per_if.wdata;
		@(posedge core_clk iff per_if.bvalid === 1'b1);
		chk_flag("p_awready", 1'b0, per_if.awready);
		chk_flag("p_busy", 1'b1, p_busy);
		repeat (3) begin
			@(posedge core_clk);
			chk_flag("p_bvalid", 1'b1, per_if.bvalid);
		end
		chk_val("p_bid", 68'h0, 68'(per_if.bid));
		chk_val("p_bresp", 68'(aswp_pkg::RESP_OKAY), 68'(per_if.bresp));
		per_if.bready <= 1'b1;
		@(posedge core_clk);
		per_if.bready <= 1'b0;
		@(posedge core_clk);
		chk_flag("p_bvalid", 1'b0, per_if.bvalid);
		chk_flag("p_awready", 1'b1, per_if.awready);
		chk_flag("p_busy", 1'b0, p_busy);
		chk_val("p_beats", 68'h2, 68'(pgot.size()));
		for (int k = 0; k < pgot.size(); k++)
			chk_val("p_beat", bexp(32'h0200 + 32'(4 * k), bdat(k, 4'h9), bstrb(k)), pgot[k]);
		$display("peripheral build done");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		$display("[ERR] watchdog expected finish seen timeout");
		summarize();
	end
	initial begin
		{rst_n, cmd_valid, cmd_addr, cmd_len, cmd_size, cmd_burst, cmd_id, dat_valid, dat_data, dat_strb} = '0;
		{per_if.awid, per_if.awaddr, per_if.awlen, per_if.awsize, per_if.awburst, per_if.awvalid} = '0;
		{per_if.wdata, per_if.wstrb, per_if.wlast, per_if.wvalid, per_if.bready} = '0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_bursts();
		t_lengths();
		t_periph();
		t_reset();
		summarize();
	end
endmodule
